// file: verif/epmp_mem_model.sv
// Asynchronous program memory behind the port
`timescale 1ns/1ps
`default_nettype none
module epmp_mem_model #(parameter int ACC_NS = 20) (
  input wire logic sel_n_in, // Select
  input wire logic rd_n_in, // Read
  input wire logic wr_n_in, // Write
  input wire logic [15:0] addr_in, // Address
  input wire logic [23:0] data_in, // Bus level
  output logic [23:0] data_out // Read drive
);
  logic [23:0] mem [0:255];
  initial data_out = 24'hA5A5A5;
  // Transparent while the write strobe is low
  always @(wr_n_in, sel_n_in, data_in, addr_in)
    if (!wr_n_in && !sel_n_in) mem[addr_in[7:0]] = data_in;
  // Released bus flips, so a stale value never passes
  always @(rd_n_in, sel_n_in, addr_in) begin
    data_out = ~data_out;
    if (!rd_n_in && !sel_n_in) data_out = #ACC_NS mem[addr_in[7:0]];
  end
endmodule
`default_nettype wire

// file: verif/epmp_port_chk.sv
// Assertions on the program memory port
`timescale 1ns/1ps
`default_nettype none
`include "epmp_defs.svh"
module epmp_port_chk #(parameter int WAIT_STATES = 1) (
  input wire logic clk_in, // Clock
  input wire logic rst_b_in, // Reset
  input wire logic req_valid_in, // Request
  input wire logic req_write_in, // Write
  input wire logic [`EPMP_ADDR_W-1:0] req_addr_in, // Address
  input wire logic req_ready_out, // Ready
  input wire logic done_out, // Done
  input wire logic trace_mode_in, // Tracing
  input wire logic move_valid_in, // Move
  input wire logic [`EPMP_ADDR_W-1:0] move_addr_in, // Move address
  input wire logic [`EPMP_ADDR_W-1:0] ext_addr_bus_out, // Bus address
  input wire logic ext_data_bus_oe_n_out, // Bus drive
  input wire logic mem_select_n_out, // Select
  input wire logic rd_n_out, // Read
  input wire logic wr_n_out, // Write
  input wire logic trace_strobe_n_out // Trace
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire take = req_valid_in && req_ready_out;
  property p_rst; $rose(rst_b_in) |-> mem_select_n_out && rd_n_out &&
    wr_n_out && ext_data_bus_oe_n_out && trace_strobe_n_out; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_excl; !rd_n_out |-> wr_n_out; endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
  property p_oe; !ext_data_bus_oe_n_out |-> !wr_n_out; endproperty
  a_oe: assert property (p_oe) else $error("bus driven");
  // Strobe width follows the wait-state count
  property p_len; take |=> !mem_select_n_out ##WAIT_STATES !mem_select_n_out
    ##1 (mem_select_n_out && done_out); endproperty
  a_len: assert property (p_len) else $error("select width");
  property p_addr; take |=> ext_addr_bus_out == $past(req_addr_in); endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_hold; req_ready_out && !req_valid_in && !trace_mode_in |=>
    $stable(ext_addr_bus_out); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_trc; req_ready_out && !req_valid_in && trace_mode_in &&
    move_valid_in |=> ext_addr_bus_out == $past(move_addr_in) &&
    !trace_strobe_n_out; endproperty
  a_trc: assert property (p_trc) else $error("trace");
  property p_off; !trace_mode_in |=> trace_strobe_n_out; endproperty
  a_off: assert property (p_off) else $error("trace off");
  c_wr: cover property (take && req_write_in);
  c_rd: cover property (take && !req_write_in);
  c_trc: cover property (!trace_strobe_n_out);
endmodule
`default_nettype wire

// file: verif/epmp_port_tb.sv
// Self-checking bench of the program memory port
`timescale 1ns/1ps
`default_nettype none
`include "epmp_defs.svh"
module epmp_port_tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, req_valid_in = 1'b0;
  logic req_write_in = 1'b0, trace_mode_in = 1'b0;
  logic fetch_valid_in = 1'b0, move_valid_in = 1'b0;
  logic [3:0] boot_mode_pins_in = 4'h0;
  logic [15:0] req_addr_in = 16'h0000, fetch_addr_in = 16'h0000;
  logic [15:0] move_addr_in = 16'h0000, ext_addr_bus_out, ta;
  logic [23:0] req_wdata_in = 24'h000000, rdata_out, ext_data_bus_out;
  logic [23:0] mout, wseen, shadow [0:255];
  logic [24:0] e, exp_q [$];
  logic req_ready_out, done_out, ext_data_bus_oe_n_out, mem_select_n_out;
  logic rd_n_out, wr_n_out, trace_strobe_n_out;
  int error_cnt = 0, check_count = 0;
  wire logic [23:0] ext_data_bus_in;
  assign ext_data_bus_in = ext_data_bus_oe_n_out ? mout : ext_data_bus_out;
  always #50 clk_in = ~clk_in;
  epmp_port dut_u (.*);
  // Slow part: data settles late in the strobe
  epmp_mem_model #(.ACC_NS(150)) mem_u (.sel_n_in(mem_select_n_out),
    .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .addr_in(ext_addr_bus_out),
    .data_in(ext_data_bus_in), .data_out(mout));
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [23:0] d);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    do @(negedge clk_in); while (req_ready_out !== 1'b1);
    @(posedge clk_in);
    exp_q.push_back({w, w ? d : shadow[a[7:0]]});
    if (w) shadow[a[7:0]] = d;
  endtask
  task test_done();
    // An access that never finished leaves its note behind
    if (exp_q.size() != 0) error_cnt++;
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk_in) begin
    if (wr_n_out === 1'b0) wseen = ext_data_bus_in;
    if (done_out === 1'b1) begin
      e = exp_q.pop_front();
      chk(e[24] ? wseen : rdata_out, e[23:0]);
    end
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(89885));
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int m = 0; m < 16; m++) begin
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      boot_mode_pins_in <= m[3:0];
      repeat (3) @(posedge clk_in);
      rst_b_in <= 1'b1;
      @(negedge clk_in);
      chk(ext_addr_bus_out, 16'(m * `EPMP_VEC_STEP - 1));
    end
    @(posedge clk_in);
    for (int i = 0; i < 16; i++)
      acc(i < 8, {8'($urandom()), 8'(i % 8)}, 24'($urandom()));
    req_valid_in <= 1'b0;
    trace_mode_in <= 1'b1;
    // Both sources, fetch alone, then fetch with tracing off
    for (int k = 0; k < 3; k++) begin
      repeat (4) @(posedge clk_in);
      move_valid_in <= k == 0;
      fetch_valid_in <= 1'b1;
      move_addr_in <= 16'($urandom());
      fetch_addr_in <= 16'($urandom());
      trace_mode_in <= k < 2;
      @(posedge clk_in);
      move_valid_in <= 1'b0;
      fetch_valid_in <= 1'b0;
      @(negedge clk_in);
      #1;
      if (k < 2) ta = k ? fetch_addr_in : move_addr_in;
      chk(ext_addr_bus_out, ta);
      chk(trace_strobe_n_out, 24'(k == 2));
    end
    test_done();
  end
endmodule
bind epmp_port epmp_port_chk #(.WAIT_STATES(WAIT_STATES)) chk_u (.*);
`default_nettype wire

// file: verilog/epmp_boot_rom.sv
// Mode to reset address lookup, minus one, registered
`timescale 1ns/1ps
`default_nettype none
`include "epmp_defs.svh"
module epmp_boot_rom #(
  parameter logic [`EPMP_ADDR_W-1:0] VEC_STEP = `EPMP_VEC_STEP
) (
  input wire logic clk_in, // Processor clock
  input wire logic [`EPMP_MODE_W-1:0] mode_in, // Selected boot mode
  output logic [`EPMP_ADDR_W-1:0] vec_m1_out // Reset address minus one
);

  logic [`EPMP_ADDR_W-1:0] table_q [`EPMP_MODES];

  // ****************************************************************
  // Table
  // ****************************************************************
  generate
    for (genvar i = 0; i < `EPMP_MODES; i++) begin : g_vec
      localparam logic [`EPMP_ADDR_W-1:0] IDX = `EPMP_ADDR_W'(i);
      assign table_q[i] = `EPMP_ADDR_W'(IDX * VEC_STEP - 16'h0001);
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    vec_m1_out <= table_q[mode_in];
  end

endmodule
`default_nettype wire

// file: verilog/epmp_defs.svh
// Constants of the external program memory port
`ifndef EPMP_DEFS_SVH
`define EPMP_DEFS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define EPMP_ADDR_W 16
`define EPMP_DATA_W 24
`define EPMP_MODE_W 4
`define EPMP_MODES 16
`define EPMP_WAIT_W 4

// ****************************************************************
// Timing and reset values
// ****************************************************************
`define EPMP_WAIT_DEFAULT 1
`define EPMP_WAIT_MAX 15
`define EPMP_ADDR_RESET 16'h0000
`define EPMP_DATA_RESET 24'h000000
// Plain default: mode n boots from n * 0x1000
`define EPMP_VEC_STEP 16'h1000

`endif

// file: verilog/epmp_pkg.sv
// Types of the external program memory port
`include "epmp_defs.svh"
package epmp_pkg;

  typedef enum logic [1:0] {
    EPMP_IDLE = 2'b00,
    EPMP_ACCESS = 2'b01
  } epmp_state_t;

  typedef struct packed {
    epmp_state_t state;
    logic [`EPMP_WAIT_W-1:0] wait_cnt;
    logic is_write;
    logic [`EPMP_ADDR_W-1:0] addr;
    logic [`EPMP_DATA_W-1:0] wdata;
    logic [`EPMP_DATA_W-1:0] rdata;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic data_oe_n;
    logic done;
    logic trace;
  } epmp_regs_t;

endpackage

// file: verilog/epmp_port.sv
// External program memory port: bus cycles, tracing and reset address
`timescale 1ns/1ps
`default_nettype none
`include "epmp_defs.svh"
module epmp_port #(
  parameter int WAIT_STATES = `EPMP_WAIT_DEFAULT
) (
  input wire logic clk_in, // Processor clock, 10 MHz
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic [`EPMP_MODE_W-1:0] boot_mode_pins_in, // Mode pins
  input wire logic req_valid_in, // Core access request
  input wire logic req_write_in, // Request is a write
  input wire logic [`EPMP_ADDR_W-1:0] req_addr_in, // Request address
  input wire logic [`EPMP_DATA_W-1:0] req_wdata_in, // Write data
  output logic req_ready_out, // Ready for a request this cycle
  output logic done_out, // Access finished, one cycle
  output logic [`EPMP_DATA_W-1:0] rdata_out, // Read data
  input wire logic trace_mode_in, // Address tracing mode on
  input wire logic fetch_valid_in, // Internal fetch this cycle
  input wire logic [`EPMP_ADDR_W-1:0] fetch_addr_in, // Fetch address
  input wire logic move_valid_in, // Internal program move
  input wire logic [`EPMP_ADDR_W-1:0] move_addr_in, // Move address
  output logic [`EPMP_ADDR_W-1:0] ext_addr_bus_out, // Address bus
  input wire logic [`EPMP_DATA_W-1:0] ext_data_bus_in, // Data bus in
  output logic [`EPMP_DATA_W-1:0] ext_data_bus_out, // Data bus out
  output logic ext_data_bus_oe_n_out, // Data bus enable, low drives
  output logic mem_select_n_out, // Memory select, active low
  output logic rd_n_out, // Read strobe, active low
  output logic wr_n_out, // Write strobe, active low
  output logic trace_strobe_n_out // Trace strobe, active low
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (WAIT_STATES < 0 || WAIT_STATES > `EPMP_WAIT_MAX) begin : g_chk
    $error("WAIT_STATES out of range");
  end

  localparam logic [`EPMP_WAIT_W-1:0] WAIT_CNT =
    `EPMP_WAIT_W'(WAIT_STATES);

  epmp_pkg::epmp_regs_t regs;
  epmp_pkg::epmp_regs_t next_regs;
  logic [`EPMP_ADDR_W-1:0] reset_vec;
  logic start;

  // ****************************************************************
  // Reset address lookup
  // ****************************************************************
  epmp_boot_rom u_rom (
    .clk_in(clk_in),
    .mode_in(boot_mode_pins_in),
    .vec_m1_out(reset_vec)
  );

  assign req_ready_out = rst_b_in && (regs.state == epmp_pkg::EPMP_IDLE);
  assign start = req_valid_in && req_ready_out;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_regs = regs;
    next_regs.done = 1'b0;
    next_regs.trace = 1'b0;
    unique case (regs.state)
      epmp_pkg::EPMP_IDLE: begin
        if (start) begin
          next_regs.state = epmp_pkg::EPMP_ACCESS;
          next_regs.wait_cnt = WAIT_CNT;
          next_regs.is_write = req_write_in;
          next_regs.addr = req_addr_in;
          next_regs.wdata = req_wdata_in;
          next_regs.cs_n = 1'b0;
          next_regs.rd_n = req_write_in;
          next_regs.wr_n = ~req_write_in;
          next_regs.data_oe_n = ~req_write_in;
          next_regs.trace = trace_mode_in;
        end else if (trace_mode_in && move_valid_in) begin
          // Moves win over fetches; only one address per cycle fits
          next_regs.addr = move_addr_in;
          next_regs.trace = 1'b1;
        end else if (trace_mode_in && fetch_valid_in) begin
          next_regs.addr = fetch_addr_in;
          next_regs.trace = 1'b1;
        end
      end
      epmp_pkg::EPMP_ACCESS: begin
        if (regs.wait_cnt == '0) begin
          next_regs.state = epmp_pkg::EPMP_IDLE;
          if (!regs.is_write) begin
            next_regs.rdata = ext_data_bus_in;
          end
          next_regs.cs_n = 1'b1;
          next_regs.rd_n = 1'b1;
          next_regs.wr_n = 1'b1;
          next_regs.data_oe_n = 1'b1;
          next_regs.done = 1'b1;
        end else begin
          next_regs.wait_cnt = regs.wait_cnt - 1'b1;
        end
      end
      // Unused codes of the 2-bit state fall back to idle
      default: begin
        next_regs.state = epmp_pkg::EPMP_IDLE;
      end
    endcase
    if (!rst_b_in) begin
      next_regs.state = epmp_pkg::EPMP_IDLE;
      next_regs.wait_cnt = '0;
      next_regs.is_write = 1'b0;
      // Follows the mode pins two cycles late for the whole reset
      next_regs.addr = reset_vec;
      next_regs.wdata = `EPMP_DATA_RESET;
      next_regs.rdata = `EPMP_DATA_RESET;
      next_regs.cs_n = 1'b1;
      next_regs.rd_n = 1'b1;
      next_regs.wr_n = 1'b1;
      next_regs.data_oe_n = 1'b1;
      next_regs.done = 1'b0;
      next_regs.trace = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    regs <= next_regs;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ext_addr_bus_out = regs.addr;
  assign ext_data_bus_out = regs.wdata;
  assign ext_data_bus_oe_n_out = regs.data_oe_n;
  assign mem_select_n_out = regs.cs_n;
  assign rd_n_out = regs.rd_n;
  assign wr_n_out = regs.wr_n;
  assign done_out = regs.done;
  assign rdata_out = regs.rdata;
  // Gated by the clock low phase: half a cycle without a second clock
  assign trace_strobe_n_out = ~(regs.trace & ~clk_in);

endmodule
`default_nettype wire

// file: verilog/epmp_port_note_end.sv
// Intentionally empty companion file marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
